// file: hw/card_interface_sequencer.sv
// activation and deactivation sequencer of a smart-card interface
// ==========================================================
// Notes on behaviour
// - falling edge of activation request starts activation sequence
// - card reset follows request once sequencer enables
// - voltage select high chooses higher card supply
// - two select inputs choose card clock ratio
// - halt input high stops card clock
// - halted clock sits at chosen level
// - outside session interrupt shows card presence only
// - faults during session pull interrupt, start deactivation
// - digital and regulator supervisors monitored continuously, card supply once ramped during activation
// - any supervisor fault forces deactivation
// - regulator supply below card supply is fault
// - digital supply initialises sequencer, faults deactivate
// - sequencer switches card regulator on and off
// - over-temperature deactivates card and reports fault
// - 00 eighth, 01 quarter, 11 half, 10 undivided
// - activation ignored during power-on delay
// - card reset held low for card clock count
// - deactivate: reset, clock, io, then supply
`default_nettype none
module card_interface_sequencer #(
  parameter int unsigned POR_CYC  = card_pkg::POR_DELAY_CYC,
  parameter int unsigned RST_HOLD = card_pkg::RST_HOLD_CARD_CYC,
  parameter int unsigned STEP     = card_pkg::STEP_CYC
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  // host control and supervisors
  input  wire card_pkg::host_ctrl_t host_i,
  input  wire card_pkg::supervisor_t sup_i,
  input  wire logic                 oscillator_input_i,
  // card side
  output card_pkg::card_out_t       card_o,
  // open-drain interrupt, low when driven
  output logic                      interrupt_n_o,
  output logic                      interrupt_oe_o
);
  localparam int unsigned HW = $bits(card_pkg::host_ctrl_t);
  localparam int unsigned SW = $bits(card_pkg::supervisor_t);
  localparam int unsigned PW = $clog2(POR_CYC + 1);
  localparam int unsigned RW = $clog2(RST_HOLD + 1);
  localparam int unsigned TW = $clog2(STEP + 1);
  localparam logic [PW-1:0] POR_LAST = PW'(POR_CYC);
  localparam logic [RW-1:0] RST_LAST = RW'(RST_HOLD);
  localparam logic [TW-1:0] STEP_LAST = TW'(STEP - 1);

  // ==========================================================
  // input synchronisation
  logic [HW+SW:0]        sync_w;
  card_pkg::host_ctrl_t  host_s;
  card_pkg::supervisor_t sup_s;
  logic                  osc_s;

  sync_bank #(
    .W       (HW + SW + 1),
    // request line idles high, so reset shows no request and no edge
    .RST_VAL ({1'b1, {(HW + SW){1'b0}}})
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .async_i ({host_i, sup_i, oscillator_input_i}),
    .sync_o  (sync_w)
  );
  assign host_s = card_pkg::host_ctrl_t'(sync_w[HW+SW:SW+1]);
  assign sup_s  = card_pkg::supervisor_t'(sync_w[SW:1]);
  assign osc_s  = sync_w[0];

  // ==========================================================
  // state
  card_pkg::seq_state_t state_r;
  card_pkg::seq_state_t state_nxt;
  logic [PW-1:0]        por_cnt_r;
  logic [PW-1:0]        por_cnt_nxt;
  logic [TW-1:0]        step_cnt_r;
  logic [TW-1:0]        step_cnt_nxt;
  logic [RW-1:0]        rst_cnt_r;
  logic [RW-1:0]        rst_cnt_nxt;
  logic                 cmd_d_r;
  logic                 fault_r;
  logic                 fault_nxt;
  logic                 irq_n_r;
  logic                 irq_n_nxt;
  card_pkg::card_out_t  out_r;
  card_pkg::card_out_t  out_nxt;

  logic session;
  logic por_ready;
  logic step_done;
  logic in_activation;
  logic vcc_check;
  logic fault_now;
  logic start;
  logic card_clock_w;
  logic card_rise_w;
  logic clk_en;

  assign session   = ~host_s.activation_command_n;
  assign por_ready = (por_cnt_r == POR_LAST);
  assign step_done = (step_cnt_r >= STEP_LAST);
  assign in_activation = (state_r == card_pkg::S_VCC_UP)
                       | (state_r == card_pkg::S_IO_ON)
                       | (state_r == card_pkg::S_ACTIVE);
  // card supply is judged only once it has had time to ramp
  assign vcc_check = (state_r == card_pkg::S_IO_ON)
                   | (state_r == card_pkg::S_ACTIVE)
                   | ((state_r == card_pkg::S_VCC_UP) & step_done);
  assign fault_now = ~sup_s.card_present
                   | ~sup_s.digital_supply_ok
                   | ~sup_s.regulator_supply_ok
                   | (vcc_check & ~sup_s.card_supply_ok)
                   | sup_s.over_temperature
                   | sup_s.over_current;
  // activation is edge triggered on the falling request
  assign start = session & cmd_d_r & por_ready
               & sup_s.card_present & sup_s.digital_supply_ok
               & ~sup_s.over_temperature & sup_s.regulator_supply_ok;

  // ==========================================================
  // power-on delay
  always_comb begin
    if (!sup_s.digital_supply_ok) begin
      por_cnt_nxt = '0;
    end else if (!por_ready) begin
      por_cnt_nxt = por_cnt_r + PW'(1);
    end else begin
      por_cnt_nxt = por_cnt_r;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      por_cnt_r <= '0;
    end else begin
      por_cnt_r <= por_cnt_nxt;
    end
  end

  // ==========================================================
  // sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      card_pkg::S_IDLE: begin
        if (start) begin
          state_nxt = card_pkg::S_VCC_UP;
        end
      end
      card_pkg::S_VCC_UP,
      card_pkg::S_IO_ON,
      card_pkg::S_ACTIVE: begin
        if (fault_now || !session) begin
          state_nxt = card_pkg::S_D_RST;
        end else if (step_done && state_r == card_pkg::S_VCC_UP) begin
          state_nxt = card_pkg::S_IO_ON;
        end else if (step_done && state_r == card_pkg::S_IO_ON) begin
          state_nxt = card_pkg::S_ACTIVE;
        end
      end
      card_pkg::S_D_RST: begin
        if (step_done) begin
          state_nxt = card_pkg::S_D_CLK;
        end
      end
      card_pkg::S_D_CLK: begin
        if (step_done) begin
          state_nxt = card_pkg::S_D_IO;
        end
      end
      card_pkg::S_D_IO: begin
        if (step_done) begin
          state_nxt = card_pkg::S_D_VCC;
        end
      end
      card_pkg::S_D_VCC: begin
        if (step_done) begin
          state_nxt = card_pkg::S_IDLE;
        end
      end
      default: state_nxt = card_pkg::S_IDLE;
    endcase

    if (state_nxt != state_r) begin
      step_cnt_nxt = '0;
    end else if (!step_done) begin
      step_cnt_nxt = step_cnt_r + TW'(1);
    end else begin
      step_cnt_nxt = step_cnt_r;
    end

    if (state_r != card_pkg::S_ACTIVE) begin
      rst_cnt_nxt = '0;
    end else if (card_rise_w && rst_cnt_r != RST_LAST) begin
      rst_cnt_nxt = rst_cnt_r + RW'(1);
    end else begin
      rst_cnt_nxt = rst_cnt_r;
    end

    // fault stays latched for the whole request
    fault_nxt = session & (fault_r | fault_now);
    if (session) begin
      irq_n_nxt = ~fault_nxt;
    end else begin
      irq_n_nxt = sup_s.card_present;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r    <= card_pkg::S_IDLE;
      step_cnt_r <= '0;
      rst_cnt_r  <= '0;
      cmd_d_r    <= 1'b1;
      fault_r    <= 1'b0;
      irq_n_r    <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      step_cnt_r <= step_cnt_nxt;
      rst_cnt_r  <= rst_cnt_nxt;
      cmd_d_r    <= host_s.activation_command_n;
      fault_r    <= fault_nxt;
      irq_n_r    <= irq_n_nxt;
    end
  end

  // ==========================================================
  // card signals
  assign clk_en = (state_r == card_pkg::S_ACTIVE)
                | (state_r == card_pkg::S_D_RST);

  card_clock_gen u_clk (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .enable_i     (clk_en),
    .halt_i       (host_s.card_clock_halt),
    .halt_level_i (host_s.halted_clock_level),
    .div_sel_i    ({host_s.clock_divider_sel_a,
                    host_s.clock_divider_sel_b}),
    .osc_i        (osc_s),
    .card_clock_o (card_clock_w),
    .card_rise_o  (card_rise_w)
  );

  always_comb begin
    out_nxt.regulator_on = in_activation
                         | (state_r == card_pkg::S_D_RST)
                         | (state_r == card_pkg::S_D_CLK)
                         | (state_r == card_pkg::S_D_IO);
    // supply level may only change while the card is unpowered
    if (state_r == card_pkg::S_IDLE) begin
      out_nxt.voltage_high = host_s.card_voltage_select;
    end else begin
      out_nxt.voltage_high = out_r.voltage_high;
    end
    out_nxt.card_io_on = (state_r == card_pkg::S_IO_ON)
                       | (state_r == card_pkg::S_ACTIVE)
                       | (state_r == card_pkg::S_D_RST)
                       | (state_r == card_pkg::S_D_CLK);
    out_nxt.card_clock = 1'b0;
    out_nxt.card_reset = (state_r == card_pkg::S_ACTIVE)
                       & (rst_cnt_r == RST_LAST)
                       & host_s.card_reset_request;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_r <= '0;
    end else begin
      out_r <= out_nxt;
    end
  end

  always_comb begin
    card_o            = out_r;
    card_o.card_clock = card_clock_w;
  end
  assign interrupt_n_o  = irq_n_r;
  assign interrupt_oe_o = ~irq_n_r;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_start_on_fall: assert property (
    (state_r == card_pkg::S_IDLE && start)
      |=> state_r == card_pkg::S_VCC_UP ##[1:2] out_r.regulator_on)
    else $error("activation request not acted on");
  a_por_blocks: assert property (
    (state_r == card_pkg::S_IDLE && !por_ready)
      |=> state_r == card_pkg::S_IDLE)
    else $error("activation inside power-on delay");
  a_vdd_restarts: assert property (
    !sup_s.digital_supply_ok |=> por_cnt_r == '0 && !por_ready)
    else $error("power-on delay not restarted");
  a_reset_gated: assert property (
    card_o.card_reset |-> $past(state_r) == card_pkg::S_ACTIVE
      && $past(rst_cnt_r) == RST_LAST
      && $past(host_s.card_reset_request))
    else $error("card reset released too early");
  a_fault_deact: assert property (
    (in_activation && session && fault_now)
      |=> state_r == card_pkg::S_D_RST && !interrupt_n_o)
    else $error("fault did not start deactivation");
  a_idle_presence: assert property (
    (!session && $stable(sup_s.card_present))
      |=> interrupt_n_o == $past(sup_s.card_present))
    else $error("interrupt not showing presence");
  a_fault_latched: assert property (
    (session && fault_r) |=> !interrupt_n_o && interrupt_oe_o)
    else $error("fault report dropped during request");
  a_deact_order: assert property (
    (state_r == card_pkg::S_D_VCC)
      |-> !card_o.card_reset && !card_o.card_clock
          && !card_o.card_io_on ##1 !card_o.regulator_on)
    else $error("deactivation order broken");
  a_vsel_idle: assert property (
    (state_r == card_pkg::S_IDLE)
      |=> card_o.voltage_high == $past(host_s.card_voltage_select))
    else $error("voltage select not followed");

  c_reset_released: cover property (card_o.card_reset);
  c_fault_session: cover property (session && fault_now && in_activation);
  c_full_deact: cover property (state_r == card_pkg::S_D_VCC ##1
                                state_r == card_pkg::S_IDLE);
endmodule : card_interface_sequencer
`default_nettype wire

// file: hw/card_pkg.sv
// shared types and timing constants of the card interface sequencer
`default_nettype none
package card_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS     = 50;
  localparam int unsigned POR_DELAY_NS      = 10000000;
  localparam int unsigned POR_DELAY_CYC     = POR_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned STEP_TIME_NS      = 10000;
  localparam int unsigned STEP_CYC          = STEP_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned RST_HOLD_CARD_CYC = 42000;

  // ==========================================================
  // card clock divider select codes {sel_a, sel_b}
  localparam logic [1:0] DIV_BY_8 = 2'h0;
  localparam logic [1:0] DIV_BY_4 = 2'h1;
  localparam logic [1:0] DIV_BY_1 = 2'h2;
  localparam logic [1:0] DIV_BY_2 = 2'h3;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic activation_command_n;
    logic card_reset_request;
    logic card_voltage_select;
    logic clock_divider_sel_a;
    logic clock_divider_sel_b;
    logic card_clock_halt;
    logic halted_clock_level;
  } host_ctrl_t;

  typedef struct packed {
    logic card_present;
    logic digital_supply_ok;
    logic regulator_supply_ok;
    logic card_supply_ok;
    logic over_temperature;
    logic over_current;
  } supervisor_t;

  typedef struct packed {
    logic regulator_on;
    logic voltage_high;
    logic card_io_on;
    logic card_clock;
    logic card_reset;
  } card_out_t;

  typedef enum logic [7:0] {
    S_IDLE   = 8'h01,
    S_VCC_UP = 8'h02,
    S_IO_ON  = 8'h04,
    S_ACTIVE = 8'h08,
    S_D_RST  = 8'h10,
    S_D_CLK  = 8'h20,
    S_D_IO   = 8'h40,
    S_D_VCC  = 8'h80
  } seq_state_t;
endpackage : card_pkg
`default_nettype wire

// file: hw/sync_bank.sv
// two-flop synchroniser bank for asynchronous level inputs
`default_nettype none
module sync_bank #(
  parameter int unsigned  W       = 1,
  // level both stages take in reset: the idle level of each pin
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;
endmodule : sync_bank
`default_nettype wire

// file: hw/card_clock_gen.sv
// card clock divider with halt level
`default_nettype none
module card_clock_gen (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // control
  input  wire logic       enable_i,
  input  wire logic       halt_i,
  input  wire logic       halt_level_i,
  input  wire logic [1:0] div_sel_i,
  input  wire logic       osc_i,
  // card clock
  output logic            card_clock_o,
  output logic            card_rise_o
);
  logic       osc_d_r;
  logic       clk_r;
  logic       clk_nxt;
  logic       rise_r;
  logic       rise_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic       osc_rise;

  // last count of oscillator rising edges in a half period of the card clock (edges minus one)
  function automatic logic [1:0] half_last(input logic [1:0] sel);
    case (sel)
      card_pkg::DIV_BY_8: half_last = 2'h3;
      card_pkg::DIV_BY_4: half_last = 2'h1;
      default:            half_last = 2'h0;
    endcase
  endfunction : half_last

  assign osc_rise = osc_i & ~osc_d_r;

  always_comb begin
    clk_nxt = clk_r;
    cnt_nxt = cnt_r;
    if (!enable_i) begin
      clk_nxt = 1'b0;
      cnt_nxt = 2'h0;
    end else if (halt_i) begin
      clk_nxt = halt_level_i;
      cnt_nxt = 2'h0;
    end else if (div_sel_i == card_pkg::DIV_BY_1) begin
      clk_nxt = osc_i;
    end else if (osc_rise) begin
      if (cnt_r >= half_last(div_sel_i)) begin
        clk_nxt = ~clk_r;
        cnt_nxt = 2'h0;
      end else begin
        cnt_nxt = cnt_r + 2'h1;
      end
    end
    rise_nxt = clk_nxt & ~clk_r & enable_i & ~halt_i;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_d_r <= 1'b0;
      clk_r   <= 1'b0;
      rise_r  <= 1'b0;
      cnt_r   <= 2'h0;
    end else begin
      osc_d_r <= osc_i;
      clk_r   <= clk_nxt;
      rise_r  <= rise_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign card_clock_o = clk_r;
  assign card_rise_o  = rise_r;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_halt_holds_level: assert property (
    (enable_i && halt_i) |=> (card_clock_o == $past(halt_level_i)))
    else $error("halted card clock not at chosen level");
  a_off_clock_low: assert property (
    !enable_i |=> !card_clock_o && !card_rise_o)
    else $error("card clock not low while disabled");
  a_div2_toggles: assert property (
    (enable_i && !halt_i && div_sel_i == card_pkg::DIV_BY_2
     && osc_rise) |=> (card_clock_o != $past(card_clock_o)))
    else $error("half rate clock missed a toggle");
  c_halted: cover property (enable_i && halt_i && halt_level_i);
endmodule : card_clock_gen
`default_nettype wire

// file: tb/card_far_model.sv
// far-side model: card presence, supply supervisors and oscillator
`default_nettype none
module card_far_model (
  // clock
  input  wire logic                   clk_i,
  // commands of the bench
  input  wire logic                   card_in_i,
  input  wire logic [2:0]             fault_i,
  // towards the device
  output var  card_pkg::supervisor_t  sup_o,
  output var  logic                   osc_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [1:0] osc_cnt = 2'h0;

  // ==========================================================
  // free-running crystal, four clock cycles a period
  always @(posedge clk_i) begin
    osc_cnt <= osc_cnt + 2'h1;
  end
  always_comb osc_o = osc_cnt[1];

  // ==========================================================
  // one fault at a time: 1 card gone, 2 digital, 3 regulator below
  // card supply, 4 card supply, 5 over-temperature, 6 over-current
  always_comb begin
    sup_o.card_present        = card_in_i && (fault_i != 3'h1);
    sup_o.digital_supply_ok   = (fault_i != 3'h2);
    sup_o.regulator_supply_ok = (fault_i != 3'h3);
    sup_o.card_supply_ok      = (fault_i != 3'h4);
    sup_o.over_temperature    = (fault_i == 3'h5);
    sup_o.over_current        = (fault_i == 3'h6);
  end
endmodule : card_far_model
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench of the card interface sequencer
`default_nettype none
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("unexpected at %0t: got %h want %h", $time, (g), (e)); \
  end \
end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // shortened counts and bench state
  localparam int unsigned POR   = 20;
  localparam int unsigned HOLD  = 8;
  localparam int unsigned STP   = 4;
  localparam int unsigned OSC   = 4;
  localparam int unsigned LIMIT = 20000;

  logic                  clk_i   = 1'b0;
  logic                  rst_b_i = 1'b0;
  card_pkg::host_ctrl_t  host    = 7'h40;
  card_pkg::supervisor_t sup;
  card_pkg::card_out_t   card_o;
  logic                  osc;
  logic                  int_n;
  logic                  int_oe;
  logic                  card_in = 1'b0;
  logic [2:0]            fault   = 3'h0;
  logic [31:0]           rnd     = 32'hfe3e761e;
  int                    n_fail  = 0;
  int                    samples_checked = 0;
  int                    cyc = 0;
  int                    i, n, t_rst, t_io, t_reg;

  always #25 clk_i = ~clk_i;

  card_interface_sequencer #(.POR_CYC(POR), .RST_HOLD(HOLD), .STEP(STP)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .host_i(host), .sup_i(sup),
    .oscillator_input_i(osc), .card_o(card_o),
    .interrupt_n_o(int_n), .interrupt_oe_o(int_oe));

  card_far_model far (
    .clk_i(clk_i), .card_in_i(card_in), .fault_i(fault),
    .sup_o(sup), .osc_o(osc));

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr

  function automatic int div_of(input logic [1:0] code);
    case (code)
      card_pkg::DIV_BY_8: return 8;
      card_pkg::DIV_BY_4: return 4;
      card_pkg::DIV_BY_2: return 2;
      default:            return 1;
    endcase
  endfunction : div_of

  task automatic step(input int k);
    repeat (k) @(negedge clk_i);
  endtask : step

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // counts card clock rises, optionally until card reset rises
  task automatic count_rises(input int k, input logic till_rst);
    logic prev;
    n = 0;
    prev = card_o.card_clock;
    for (i = 0; i < k; i++) begin
      if (till_rst && card_o.card_reset === 1'b1) break;
      step(1);
      if (card_o.card_clock === 1'b1 && prev === 1'b0) n++;
      prev = card_o.card_clock;
    end
  endtask : count_rises

  // fresh fall of the activation command, returns once i/o is on
  task automatic activate();
    @(posedge clk_i) host.activation_command_n <= 1'b1;
    step(4);
    @(posedge clk_i) host.activation_command_n <= 1'b0;
    for (i = 0; i < 60 && card_o.card_io_on !== 1'b1; i++) step(1);
  endtask : activate

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_fail++;
      give_verdict();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    step(6);
    `CHK(int_n, 1'b0)
    `CHK(int_oe, 1'b1)
    // request inside the power-on delay is ignored
    @(posedge clk_i) begin
      card_in <= 1'b1;
      host.activation_command_n <= 1'b0;
    end
    step(30);
    `CHK(card_o.regulator_on, 1'b0)
    // thermal fault outside a session stays silent, blocks activation
    @(posedge clk_i) begin
      host.activation_command_n <= 1'b1;
      fault <= 3'h5;
    end
    step(10);
    `CHK(int_n, 1'b1)
    @(posedge clk_i) host.activation_command_n <= 1'b0;
    step(30);
    `CHK(card_o.regulator_on, 1'b0)
    `CHK(int_n, 1'b0)
    @(posedge clk_i) begin
      host.activation_command_n <= 1'b1;
      fault <= 3'h0;
    end
    step(10);
    // session with random voltage, card reset requested early
    rnd = lfsr(rnd);
    @(posedge clk_i) begin
      host.card_voltage_select <= rnd[0];
      host.card_reset_request <= 1'b1;
      {host.clock_divider_sel_a, host.clock_divider_sel_b} <= 2'h3;
    end
    activate();
    `CHK(card_o.regulator_on, 1'b1)
    `CHK(card_o.voltage_high, rnd[0])
    `CHK(card_o.card_io_on, 1'b1)
    count_rises(400, 1'b1);
    `CHK(n, HOLD)
    @(posedge clk_i) host.card_reset_request <= 1'b0;
    step(5);
    `CHK(card_o.card_reset, 1'b0)
    @(posedge clk_i) host.card_reset_request <= 1'b1;
    step(5);
    `CHK(card_o.card_reset, 1'b1)
    // every divider code, rises in a window of 128 cycles
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_i)
        {host.clock_divider_sel_a, host.clock_divider_sel_b} <= c[1:0];
      step(40);
      count_rises(128, 1'b0);
      `CHK(n, 128 / (OSC * div_of(c[1:0])))
    end
    // halted clock sits at a random level
    rnd = lfsr(rnd);
    @(posedge clk_i) begin
      host.card_clock_halt <= 1'b1;
      host.halted_clock_level <= rnd[1];
    end
    step(8);
    repeat (4) begin
      `CHK(card_o.card_clock, rnd[1])
      step(3);
    end
    @(posedge clk_i) host.card_clock_halt <= 1'b0;
    step(8);
    // host-ordered deactivation, i/o falls two steps after reset, regulator one step after i/o
    t_rst = 0;
    t_io = 0;
    t_reg = 0;
    @(posedge clk_i) host.activation_command_n <= 1'b1;
    for (int k = 1; k < 60; k++) begin
      step(1);
      if (t_rst == 0 && card_o.card_reset === 1'b0) t_rst = k;
      if (t_io == 0 && card_o.card_io_on === 1'b0) begin
        t_io = k;
        `CHK(card_o.card_clock, 1'b0)
      end
      if (t_reg == 0 && card_o.regulator_on === 1'b0) t_reg = k;
    end
    `CHK(t_io - t_rst, 2 * STP)
    `CHK(t_reg - t_io, STP)
    // every fault kind during a session
    for (int k = 1; k <= 6; k++) begin
      step(4 * STP + POR + 10);
      rnd = lfsr(rnd);
      @(posedge clk_i) host.card_voltage_select <= rnd[0];
      activate();
      `CHK(card_o.voltage_high, rnd[0])
      step(STP + 2);
      @(posedge clk_i) fault <= k[2:0];
      step(6);
      `CHK(int_n, 1'b0)
      `CHK(int_oe, 1'b1)
      step(5 * STP + 4);
      `CHK(card_o.regulator_on, 1'b0)
      `CHK(card_o.card_io_on, 1'b0)
      @(posedge clk_i) fault <= 3'h0;
      step(10);
      `CHK(int_n, 1'b0)
      @(posedge clk_i) host.activation_command_n <= 1'b1;
      step(6);
      `CHK(int_n, 1'b1)
    end
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
